// File: verilog/adc_conversion_control.v
// Overview of operation
// - each conversion yields a 10-bit result after sample and hold
// - 24 channels, sixteen on group A and eight on group B
// - one control bit picks which port group supplies channels
// - sample time and conversion time are programmable
// - self-calibration after every reset, at most 40630 cycles
// - busy flag set during calibration, no conversion meanwhile
// - overrun request when result completes before previous was read
// - optional hold-off of next conversion until previous is read
// - single channel once: convert selected channel one time
// - single channel continuous: convert selected channel repeatedly
// - scan once: convert each selected channel once, store each
// - scan continuous: cycle through selected channels repeatedly
// - in scan modes each stored result raises a service request
// - wait-for-read in continuous modes buffers new result and pauses until read
// - one injected conversion during continuous mode, own register
// - unused analog pins stay readable as digital inputs
//
// Purpose: sequencing control for the analog-to-digital converter
// Assumes: control bits are plain ports sampled on the clock
// Notes: calibration count is a parameter so simulation can shorten it
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"
module adc_conversion_control #(
	parameter CAL_CYCLES = `CAL_CYCLES,
	parameter WIDTH = `RESULT_WIDTH,
	parameter TW = `TIME_WIDTH
) (
	input wire clk_in, // clock
	input wire rst_in, // async reset, active high
	input wire start_in, // start conversion pulse
	input wire stop_in, // end continuous mode pulse
	input wire [1:0] mode_in, // conversion mode
	input wire [4:0] channel_in, // channel, or scan top channel
	input wire group_sel_in, // 0 group A, 1 group B
	input wire overrun_hold_in, // suspend instead of flag overrun
	input wire wait_for_read_enable_in, // wait-for-read in continuous
	input wire [TW-1:0] sample_time_in, // sample cycles
	input wire [TW-1:0] conv_time_in, // conversion cycles
	input wire inject_req_in, // injection request pulse
	input wire [4:0] inject_channel_in, // injected channel
	input wire result_read_in, // result register read pulse
	input wire inject_read_in, // injection result read pulse
	input wire [16*WIDTH-1:0] group_a_level_in, // group A levels
	input wire [8*WIDTH-1:0] group_b_level_in, // group B levels
	input wire [15:0] group_a_pin_in, // group A digital pins
	input wire [7:0] group_b_pin_in, // group B digital pins
	output reg converter_busy_flag_out, // calibration or conversion
	output reg [WIDTH-1:0] conversion_result_register_out, // result
	output reg [4:0] result_channel_out, // channel of result
	output reg [WIDTH-1:0] injection_result_register_out, // injected
	output reg result_request_out, // one-cycle result request
	output reg overrun_irq_out, // one-cycle overrun request
	output reg inject_done_out, // one-cycle injection done
	output reg [15:0] group_a_digital_out, // digital read, group A
	output reg [7:0] group_b_digital_out // digital read, group B
);
	localparam ST_CAL = 3'h0;
	localparam ST_IDLE = 3'h1;
	localparam ST_CONV = 3'h2;
	localparam ST_WAIT = 3'h3;
	localparam ST_INJ = 3'h4;
	localparam CW = 16;

	// level of one channel from the selected group
	function [WIDTH-1:0] pick_level;
		input grp;
		input [4:0] ch;
		input [16*WIDTH-1:0] a;
		input [8*WIDTH-1:0] b;
		begin
			if (grp)
				pick_level = b[ch[2:0]*WIDTH +: WIDTH];
			else
				pick_level = a[ch[3:0]*WIDTH +: WIDTH];
		end
	endfunction

	reg [2:0] state;
	reg [CW-1:0] cal_count;
	reg [1:0] mode;
	reg [4:0] top_chan;
	reg [4:0] cur_chan;
	reg grp;
	reg unread;
	reg inj_pending;
	reg [4:0] inj_chan;
	reg [WIDTH-1:0] temp_buf;
	reg [4:0] temp_chan;
	reg core_start;
	reg [WIDTH-1:0] core_level;
	reg [4:0] conv_chan;
	wire core_busy;
	wire core_done;
	wire [WIDTH-1:0] core_result;
	wire continuous = mode[0];
	wire scan = mode[1];
	wire last_chan = (cur_chan == 5'h00);

	always @* begin
		if (state == ST_INJ)
			conv_chan = inj_chan;
		else
			conv_chan = cur_chan;
		core_level = pick_level(grp, conv_chan,
			group_a_level_in, group_b_level_in);
	end

	adc_sar_core #(.WIDTH(WIDTH), .TW(TW)) u_core (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.start_in(core_start),
		.sample_time_in(sample_time_in),
		.conv_time_in(conv_time_in),
		.analog_in(core_level),
		.busy_out(core_busy),
		.done_out(core_done),
		.result_out(core_result)
	);

	// digital read of every pin, analog use does not disturb it
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_pin_a
			always @(posedge clk_in or posedge rst_in) begin
				if (rst_in)
					group_a_digital_out[g] <= 1'b0;
				else
					group_a_digital_out[g] <= group_a_pin_in[g];
			end
		end
		for (g = 0; g < 8; g = g + 1) begin : g_pin_b
			always @(posedge clk_in or posedge rst_in) begin
				if (rst_in)
					group_b_digital_out[g] <= 1'b0;
				else
					group_b_digital_out[g] <= group_b_pin_in[g];
			end
		end
	endgenerate

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_CAL;
			cal_count <= {CW{1'b0}};
			converter_busy_flag_out <= 1'b1;
			mode <= `MODE_SINGLE_ONCE;
			top_chan <= 5'h00;
			cur_chan <= 5'h00;
			grp <= 1'b0;
			unread <= 1'b0;
			inj_pending <= 1'b0;
			inj_chan <= 5'h00;
			temp_buf <= {WIDTH{1'b0}};
			temp_chan <= 5'h00;
			core_start <= 1'b0;
			conversion_result_register_out <= {WIDTH{1'b0}};
			result_channel_out <= 5'h00;
			injection_result_register_out <= {WIDTH{1'b0}};
			result_request_out <= 1'b0;
			overrun_irq_out <= 1'b0;
			inject_done_out <= 1'b0;
		end else begin
			core_start <= 1'b0;
			result_request_out <= 1'b0;
			overrun_irq_out <= 1'b0;
			inject_done_out <= 1'b0;
			if (result_read_in)
				unread <= 1'b0;
			if (inject_req_in && continuous && state != ST_IDLE
				&& state != ST_CAL) begin
				inj_pending <= 1'b1;
				inj_chan <= inject_channel_in;
			end
			case (state)
			ST_CAL: begin
				if (cal_count == CAL_CYCLES[CW-1:0] - 1'b1) begin
					state <= ST_IDLE;
					converter_busy_flag_out <= 1'b0;
				end else
					cal_count <= cal_count + 1'b1;
			end
			ST_IDLE: begin
				if (start_in) begin
					mode <= mode_in;
					grp <= group_sel_in;
					top_chan <= channel_in;
					cur_chan <= channel_in;
					inj_pending <= 1'b0;
					state <= ST_CONV;
					core_start <= 1'b1;
					converter_busy_flag_out <= 1'b1;
				end
			end
			ST_CONV: begin
				if (core_done) begin
					if (unread && !result_read_in
						&& (wait_for_read_enable_in && continuous
						|| overrun_hold_in)) begin
						temp_buf <= core_result;
						temp_chan <= cur_chan;
						state <= ST_WAIT;
					end else begin
						if (unread && !result_read_in)
							overrun_irq_out <= 1'b1;
						conversion_result_register_out <= core_result;
						result_channel_out <= cur_chan;
						unread <= 1'b1;
						result_request_out <= 1'b1;
						if (scan)
							cur_chan <= last_chan ? top_chan
								: cur_chan - 5'h01;
						if (stop_in || !continuous
							&& (!scan || last_chan)) begin
							state <= ST_IDLE;
							converter_busy_flag_out <= 1'b0;
						end else if (inj_pending) begin
							state <= ST_INJ;
							core_start <= 1'b1;
						end else
							core_start <= 1'b1;
					end
				end
			end
			ST_WAIT: begin
				if (result_read_in) begin
					// buffered result moves up, conversion resumes unless stop_in or the end of a once run sends it to idle
					conversion_result_register_out <= temp_buf;
					result_channel_out <= temp_chan;
					unread <= 1'b1;
					result_request_out <= 1'b1;
					if (scan)
						cur_chan <= last_chan ? top_chan
							: cur_chan - 5'h01;
					if (stop_in || !continuous
						&& (!scan || last_chan)) begin
						state <= ST_IDLE;
						converter_busy_flag_out <= 1'b0;
					end else begin
						state <= ST_CONV;
						core_start <= 1'b1;
					end
				end
			end
			ST_INJ: begin
				if (core_done) begin
					injection_result_register_out <= core_result;
					inject_done_out <= 1'b1;
					inj_pending <= 1'b0;
					if (stop_in) begin
						state <= ST_IDLE;
						converter_busy_flag_out <= 1'b0;
					end else begin
						state <= ST_CONV;
						core_start <= 1'b1;
					end
				end
			end
			default: begin
				state <= ST_IDLE;
				converter_busy_flag_out <= 1'b0;
			end
			endcase
		end
	end
endmodule

// File: pkg/adc_ctrl_consts.vh
// Purpose: constants for the converter control block
// Assumes: clock of 200 MHz
// Notes: the calibration length is given in cpu clock cycles
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
`define RESULT_WIDTH 10
`define CHAN_COUNT 24
`define GROUP_A_COUNT 16
`define GROUP_B_COUNT 8
`define CHAN_WIDTH 5
`define CAL_CYCLES 40630
`define MODE_SINGLE_ONCE 2'h0
`define MODE_SINGLE_CONT 2'h1
`define MODE_SCAN_ONCE 2'h2
`define MODE_SCAN_CONT 2'h3
`define TIME_WIDTH 8
`endif

// File: verilog/adc_sar_core.v
// Purpose: one sample and conversion of a selected analog input
// Assumes: analog value arrives already digitised on a port
// Notes: sample phase then conversion phase, both counted in cycles
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"
module adc_sar_core #(
	parameter WIDTH = `RESULT_WIDTH,
	parameter TW = `TIME_WIDTH
) (
	input wire clk_in, // clock
	input wire rst_in, // async reset
	input wire start_in, // start pulse
	input wire [TW-1:0] sample_time_in, // sample cycles
	input wire [TW-1:0] conv_time_in, // conversion cycles
	input wire [WIDTH-1:0] analog_in, // selected input level
	output reg busy_out, // conversion running
	output reg done_out, // one-cycle result strobe
	output reg [WIDTH-1:0] result_out // converted value
);
	reg phase;
	reg [TW-1:0] count;
	reg [WIDTH-1:0] held;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_out <= 1'b0;
			done_out <= 1'b0;
			result_out <= {WIDTH{1'b0}};
			phase <= 1'b0;
			count <= {TW{1'b0}};
			held <= {WIDTH{1'b0}};
		end else begin
			done_out <= 1'b0;
			if (!busy_out) begin
				if (start_in) begin
					busy_out <= 1'b1;
					phase <= 1'b0;
					count <= sample_time_in;
				end
			end else if (count != {TW{1'b0}}) begin
				count <= count - 1'b1;
			end else if (!phase) begin
				// sample and hold closes here
				held <= analog_in;
				phase <= 1'b1;
				count <= conv_time_in;
			end else begin
				busy_out <= 1'b0;
				done_out <= 1'b1;
				result_out <= held;
			end
		end
	end
endmodule

// File: verification/adc_ctrl_sva.sv
// Purpose: port checker for the converter control block
// Assumes: one clock, asynchronous active-high reset
// Notes: calibration length comes in as a parameter
`timescale 1ns/10ps
module adc_ctrl_sva #(
	parameter CAL_CYCLES = 20
) (
	input wire clk_in, // clock
	input wire rst_in, // reset
	input wire overrun_hold_in, // hold mode
	input wire result_read_in, // result read
	input wire [15:0] group_a_pin_in, // digital pins
	input wire converter_busy_flag_out, // busy
	input wire result_request_out, // result stored
	input wire overrun_irq_out, // overrun
	input wire inject_done_out, // injection done
	input wire [15:0] group_a_digital_out // digital read
);
localparam int CAL_MAX = CAL_CYCLES + 2;
reg unread;
default clocking @(posedge clk_in); endclocking
default disable iff (rst_in);
// a read in the store cycle counts as read
always @(posedge clk_in or posedge rst_in) begin
	if (rst_in)
		unread <= 1'b0;
	else if (result_read_in)
		unread <= 1'b0;
	else if (result_request_out)
		unread <= 1'b1;
end
AST_CAL_BUSY: assert property ($fell(rst_in) |-> converter_busy_flag_out[*8])
	else $error("busy low during calibration");
AST_CAL_END: assert property ($fell(rst_in) |->
	##[1:CAL_MAX] !converter_busy_flag_out)
	else $error("calibration too long");
AST_REQ_PULSE: assert property (result_request_out |=> !result_request_out)
	else $error("request longer than one cycle");
AST_ONCE_END: assert property (result_request_out &&
	!converter_busy_flag_out |-> $past(converter_busy_flag_out))
	else $error("result while idle");
AST_OVR_IRQ: assert property (!overrun_hold_in && unread &&
	result_request_out && !result_read_in |-> overrun_irq_out)
	else $error("overrun not flagged");
AST_OVR_CAUSE: assert property (overrun_irq_out |->
	result_request_out && !overrun_hold_in)
	else $error("overrun without cause");
AST_HOLD: assert property (overrun_hold_in && unread && !result_read_in
	|-> !result_request_out)
	else $error("store while previous unread");
AST_INJ: assert property (inject_done_out |-> converter_busy_flag_out)
	else $error("run ended by injection");
AST_DIG: assert property (1'b1 |=> group_a_digital_out ==
	$past(group_a_pin_in))
	else $error("digital pins not passed");
cover property (overrun_irq_out);
cover property (inject_done_out);
cover property (result_request_out && !converter_busy_flag_out);
endmodule
bind adc_conversion_control adc_ctrl_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (
	.clk_in(clk_in), .rst_in(rst_in), .overrun_hold_in(overrun_hold_in),
	.result_read_in(result_read_in), .group_a_pin_in(group_a_pin_in),
	.converter_busy_flag_out(converter_busy_flag_out),
	.result_request_out(result_request_out),
	.overrun_irq_out(overrun_irq_out), .inject_done_out(inject_done_out),
	.group_a_digital_out(group_a_digital_out));

// File: verification/adc_analog_source.sv
// Purpose: analog levels and digital pins seen by the converter
// Assumes: levels already digitised, distinct per channel
// Notes: channel k level is base xor k, group B adds 10'h200
`timescale 1ns/10ps
module adc_analog_source (
	input wire [9:0] base_in, // level pattern
	input wire [23:0] pin_in, // pin pattern
	output reg [159:0] group_a_level_out, // group A levels
	output reg [79:0] group_b_level_out, // group B levels
	output wire [15:0] group_a_pin_out, // group A pins
	output wire [7:0] group_b_pin_out // group B pins
);
integer k;
always @* begin
	for (k = 0; k < 16; k = k + 1) begin
		group_a_level_out[k*10+:10] = base_in ^ k[9:0];
	end
	for (k = 0; k < 8; k = k + 1) begin
		group_b_level_out[k*10+:10] = base_in ^ (10'h200 + k[9:0]);
	end
end
assign group_a_pin_out = pin_in[15:0];
assign group_b_pin_out = pin_in[23:16];
endmodule

// File: verification/tb_adc_conversion_control.sv
// Purpose: self-checking bench for the converter control block
// Assumes: calibration shortened to 20 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"
`define CHK(a, b) begin num_checks = num_checks + 1; \
	if ((a) !== (b)) begin mismatches = mismatches + 1; \
	$display("[FAIL] %0t value mismatch", $time); end end
module tb_adc_conversion_control;
reg clk_in = 1'b0;
reg rst_in = 1'b1;
reg start_in = 1'b0, stop_in = 1'b0, group_sel_in = 1'b0, inject_req_in = 1'b0;
reg overrun_hold_in = 1'b0, wfr = 1'b0, result_read_in = 1'b0;
reg [1:0] mode_in = 2'h0;
reg [4:0] channel_in = 5'h00, inject_channel_in = 5'h00, e;
reg [7:0] s_t = 8'h00, c_t = 8'h00;
reg [9:0] base = 10'h000;
reg [23:0] pins = 24'h000000;
reg [31:0] lfsr = 32'h2875;
reg [14:0] q[$];
wire [159:0] lv_a;
wire [79:0] lv_b;
wire [15:0] pa;
wire [7:0] pb;
wire busy, req, irq, ijd;
wire [9:0] res, ires;
wire [4:0] rch;
wire [15:0] ga_d;
wire [7:0] gb_d;
integer mismatches = 0, num_checks = 0, cyc = 0, nirq = 0, ninj = 0;
integer lag = 0, delay = 1, w;
adc_analog_source u_src (.base_in(base), .pin_in(pins),
	.group_a_level_out(lv_a), .group_b_level_out(lv_b),
	.group_a_pin_out(pa), .group_b_pin_out(pb));
adc_conversion_control #(.CAL_CYCLES(20)) u_dut (.clk_in(clk_in),
	.rst_in(rst_in), .start_in(start_in), .stop_in(stop_in),
	.mode_in(mode_in), .channel_in(channel_in), .group_sel_in(group_sel_in),
	.overrun_hold_in(overrun_hold_in), .wait_for_read_enable_in(wfr),
	.sample_time_in(s_t), .conv_time_in(c_t), .inject_req_in(inject_req_in),
	.inject_channel_in(inject_channel_in), .result_read_in(result_read_in),
	.inject_read_in(1'b0), .group_a_level_in(lv_a), .group_b_level_in(lv_b),
	.group_a_pin_in(pa), .group_b_pin_in(pb),
	.converter_busy_flag_out(busy), .conversion_result_register_out(res),
	.result_channel_out(rch), .injection_result_register_out(ires),
	.result_request_out(req), .overrun_irq_out(irq), .inject_done_out(ijd),
	.group_a_digital_out(ga_d), .group_b_digital_out(gb_d));
always #2.5 clk_in = ~clk_in;
function [31:0] nxt(input [31:0] v);
	nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
function [9:0] lvl(input g, input [4:0] c);
	lvl = base ^ {g, 4'h0, c};
endfunction
task end_sim;
begin
	$display("checks %0d mismatches %0d", num_checks, mismatches);
	if (mismatches == 0 && num_checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
end
endtask
// outputs taken mid-cycle, away from the edge that launches them
always @(negedge clk_in) begin
	cyc = cyc + 1;
	if (req === 1'b1)
		q.push_back({rch, res});
	if (irq === 1'b1)
		nirq = nirq + 1;
	if (ijd === 1'b1)
		ninj = ninj + 1;
	if (cyc == 20000) begin
		mismatches = mismatches + 1;
		end_sim;
	end
end
// software read, delay cycles after each stored result; 0 never reads
always @(negedge clk_in) begin
	if (req === 1'b1)
		lag = delay;
	else if (lag > 0)
		lag = lag - 1;
	result_read_in = (lag == 1);
end
task run(input [1:0] m, input [4:0] c, input g, input integer n);
	integer i;
begin
	@(negedge clk_in);
	lfsr = nxt(lfsr);
	base = lfsr[9:0];
	pins = lfsr[31:8];
	s_t = {6'h00, lfsr[1:0]};
	c_t = {6'h00, lfsr[3:2]};
	mode_in = m;
	channel_in = c;
	group_sel_in = g;
	inject_channel_in = c ^ 5'h01;
	q.delete();
	ninj = 0;
	start_in = 1'b1;
	@(negedge clk_in);
	start_in = 1'b0;
	inject_req_in = (m == 2'h1);
	@(negedge clk_in);
	inject_req_in = 1'b0;
	for (w = 0; q.size() < n && w < 2000; w = w + 1)
		@(negedge clk_in);
	stop_in = 1'b1;
	for (w = 0; busy !== 1'b0 && w < 2000; w = w + 1)
		@(negedge clk_in);
	stop_in = 1'b0;
	`CHK(busy, 1'b0)
	`CHK({gb_d, ga_d}, pins)
	`CHK(q.size() >= n, 1'b1)
	for (i = 0; i < n; i = i + 1) begin
		e = m[1] ? c - i % (c + 1) : c;
		`CHK(q[i], {e, lvl(g, e)})
	end
	if (m == 2'h1) begin
		`CHK(ninj, 1)
		`CHK(ires, lvl(g, c ^ 5'h01))
	end
end
endtask
initial begin
	repeat (3) @(posedge clk_in);
	@(negedge clk_in);
	rst_in = 1'b0;
	`CHK(busy, 1'b1)
	for (w = 0; busy !== 1'b0 && w < 100; w = w + 1)
		@(negedge clk_in);
	`CHK(w > 17 && w < 23, 1'b1)
	repeat (3) begin
		run(2'h0, {1'b0, lfsr[7:4]}, 1'b0, 1);
		run(2'h0, {2'h0, lfsr[6:4]}, 1'b1, 1);
	end
	run(2'h1, 5'h0F, 1'b0, 3);
	run(2'h1, 5'h06, 1'b1, 3);
	run(2'h2, 5'h07, 1'b1, 8);
	run(2'h3, 5'h02, 1'b0, 5);
	nirq = 0;
	delay = 40;
	wfr = 1'b1;
	run(2'h3, 5'h02, 1'b0, 4);
	`CHK(nirq, 0)
	wfr = 1'b0;
	overrun_hold_in = 1'b1;
	run(2'h2, 5'h02, 1'b0, 3);
	`CHK(nirq, 0)
	overrun_hold_in = 1'b0;
	// let the pending read of the last held result happen first
	repeat (45) @(negedge clk_in);
	delay = 0;
	run(2'h2, 5'h02, 1'b0, 3);
	`CHK(nirq, 2)
	// second reset in mid-run, calibration must run again
	@(negedge clk_in);
	mode_in = 2'h1;
	start_in = 1'b1;
	@(negedge clk_in);
	start_in = 1'b0;
	repeat (5) @(negedge clk_in);
	rst_in = 1'b1;
	repeat (3) @(negedge clk_in);
	rst_in = 1'b0;
	`CHK({busy, res}, 11'h400)
	for (w = 0; busy !== 1'b0 && w < 100; w = w + 1)
		@(negedge clk_in);
	`CHK(w > 17 && w < 23, 1'b1)
	end_sim;
end
endmodule
